// file: core/aer_regs.sv
/*
  Advanced error reporting register bank of one switch port: capability
  header, uncorrectable error status and uncorrectable error mask, with
  the logic that sets status bits from the port's detectors.
  Assumes a configuration request port in the core_clk domain, detector
  pulses from same-clock port logic, arst_n as the fundamental reset and
  hot_rst as a synchronous non-fundamental reset.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_regs
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hot_rst,
  // Configuration request port
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [aer_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [aer_pkg::BE_W-1:0] cfg_be,
  input wire logic [aer_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic cfg_wr_lock,
  output logic cfg_ack,
  output logic [aer_pkg::DATA_W-1:0] cfg_rdata,
  // Detector events, one-cycle pulses
  input wire logic link_protocol_fault,
  input wire logic unexpected_link_loss,
  input wire logic poisoned_packet,
  input wire logic credit_protocol_fault,
  input wire logic unexpected_completion,
  input wire logic receiver_overflow,
  input wire logic malformed_packet,
  input wire logic ecrc_failure,
  input wire logic unsupported_request,
  input wire logic double_bit_memory_error,
  // Enables held in other capability registers
  input wire logic link_loss_reporting_capable,
  input wire logic double_bit_reporting_enable,
  // Error reporting toward the root complex
  output logic err_report,
  output logic [aer_pkg::PTR_W-1:0] first_error_pointer,
  output logic first_error_valid
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Word compare; the two low address bits only select bytes
  function automatic logic reg_hit(
    input logic [aer_pkg::ADDR_W-1:0] addr,
    input logic [aer_pkg::ADDR_W-1:0] off);
    return addr[aer_pkg::ADDR_W-1:aer_pkg::WORD_LSB]
      == off[aer_pkg::ADDR_W-1:aer_pkg::WORD_LSB];
  endfunction : reg_hit

  // Byte enables widened to a bit mask
  function automatic logic [aer_pkg::DATA_W-1:0] lane_mask(
    input logic [aer_pkg::BE_W-1:0] be);
    logic [aer_pkg::DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < aer_pkg::BE_W; b++)
      m[b*8 +: 8] = {8{be[b]}};
    return m;
  endfunction : lane_mask

  // Cuts a word down to the positions that really hold a flag
  function automatic logic [aer_pkg::DATA_W-1:0] impl_only(
    input logic [aer_pkg::DATA_W-1:0] v,
    input logic [aer_pkg::DATA_W-1:0] impl);
    return v & impl;
  endfunction : impl_only

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic hit_cap;
  logic hit_status;
  logic hit_mask;
  logic hit_any;
  logic wr_req;
  logic rd_req;
  logic [aer_pkg::DATA_W-1:0] wr_lanes;
  logic [aer_pkg::DATA_W-1:0] wr_bits;

  assign hit_cap = reg_hit(cfg_addr, aer_pkg::OFF_CAP_HEADER);
  assign hit_status = reg_hit(cfg_addr, aer_pkg::OFF_UE_STATUS);
  assign hit_mask = reg_hit(cfg_addr, aer_pkg::OFF_UE_MASK);
  assign hit_any = hit_cap | hit_status | hit_mask;
  assign wr_req = cfg_req & cfg_write;
  assign rd_req = cfg_req & ~cfg_write;
  assign wr_lanes = lane_mask(cfg_be);
  assign wr_bits = cfg_wdata & wr_lanes;

  // ****************************************************************
  // Per-register strobes
  // ****************************************************************

  // One named strobe per register, so each store sees a single term
  // and an unmapped address can never reach any of them
  logic wr_cap;
  logic wr_status;
  logic wr_mask;
  logic rd_hit;

  assign wr_cap = wr_req & hit_cap;
  assign wr_status = wr_req & hit_status;
  assign wr_mask = wr_req & hit_mask;
  assign rd_hit = rd_req & hit_any;

  // ****************************************************************
  // Capability header
  // ****************************************************************

  // The next-capability link is the only writable field here, and
  // only while the write lock is released. It is not sticky.
  logic [aer_pkg::NXT_LINK_W-1:0] nxt_link_q;
  logic [aer_pkg::NXT_LINK_W-1:0] nxt_link_d;
  logic [aer_pkg::NXT_LINK_W-1:0] nxt_link_we;
  logic [aer_pkg::NXT_LINK_W-1:0] nxt_link_wv;
  logic nxt_link_wr;

  assign nxt_link_wr = wr_cap & ~cfg_wr_lock;
  assign nxt_link_we =
    wr_lanes[aer_pkg::NXT_LINK_LSB +: aer_pkg::NXT_LINK_W];
  assign nxt_link_wv =
    cfg_wdata[aer_pkg::NXT_LINK_LSB +: aer_pkg::NXT_LINK_W];
  assign nxt_link_d = nxt_link_wr
    ? ((nxt_link_q & ~nxt_link_we) | (nxt_link_wv & nxt_link_we))
    : nxt_link_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      nxt_link_q <= aer_pkg::NXT_LINK_RST;
    else if (hot_rst)
      nxt_link_q <= aer_pkg::NXT_LINK_RST;
    else
      nxt_link_q <= nxt_link_d;
  end

  // ****************************************************************
  // Header word
  // ****************************************************************

  logic [aer_pkg::DATA_W-1:0] cap_word;

  // Identifier and version are constants, never storage
  always_comb
  begin
    cap_word = '0;
    cap_word[aer_pkg::CAP_ID_LSB +: aer_pkg::CAP_ID_W] =
      aer_pkg::CAP_ID_VAL;
    cap_word[aer_pkg::CAP_VER_LSB +: aer_pkg::CAP_VER_W] =
      aer_pkg::CAP_VER_VAL;
    cap_word[aer_pkg::NXT_LINK_LSB +: aer_pkg::NXT_LINK_W] = nxt_link_q;
  end

  // ****************************************************************
  // Detector events
  // ****************************************************************
  logic [aer_pkg::DATA_W-1:0] evt_set;
  logic link_loss_ok;
  logic double_bit_ok;

  // Link loss only counts on ports that advertise the capability
  assign link_loss_ok = unexpected_link_loss
    & link_loss_reporting_capable;
  // A double-bit error only counts while its reporting is enabled
  assign double_bit_ok = double_bit_memory_error
    & double_bit_reporting_enable;

  // ****************************************************************
  // Event vector
  // ****************************************************************

  // Obsolete, timeout, abort and access control positions stay zero
  always_comb
  begin
    evt_set = '0;
    evt_set[aer_pkg::BIT_LINK_PROTO] = link_protocol_fault;
    evt_set[aer_pkg::BIT_LINK_LOSS] = link_loss_ok;
    evt_set[aer_pkg::BIT_POISONED] = poisoned_packet;
    evt_set[aer_pkg::BIT_CREDIT] = credit_protocol_fault;
    evt_set[aer_pkg::BIT_UNEXP_CPL] = unexpected_completion;
    evt_set[aer_pkg::BIT_RX_OVERFLOW] = receiver_overflow;
    evt_set[aer_pkg::BIT_MALFORMED] = malformed_packet;
    evt_set[aer_pkg::BIT_ECRC] = ecrc_failure;
    evt_set[aer_pkg::BIT_UNSUPPORTED] = unsupported_request;
    evt_set[aer_pkg::BIT_DOUBLE_BIT] = double_bit_ok;
  end

  // ****************************************************************
  // Uncorrectable error status
  // ****************************************************************
  logic [aer_pkg::DATA_W-1:0] status_clr;
  logic [aer_pkg::DATA_W-1:0] status_hold0;
  logic [aer_pkg::DATA_W-1:0] status_q;

  // Only ones written to enabled lanes clear; zeros do nothing
  assign status_clr = wr_status
    ? impl_only(wr_bits, aer_pkg::STATUS_IMPL)
    : '0;

  // The double-bit flag is forced to zero while its enable is off
  always_comb
  begin
    status_hold0 = '0;
    status_hold0[aer_pkg::BIT_DOUBLE_BIT] =
      ~double_bit_reporting_enable;
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************

  // Sticky flags sit on the fundamental reset only, so a hot reset
  // leaves the error history for software to collect.
  for (genvar i = 0; i < aer_pkg::DATA_W; i++)
  begin : g_status
    if (aer_pkg::STATUS_IMPL[i])
    begin : g_flag
      aer_sticky_bit u_flag (
        .core_clk (core_clk),
        .arst_n (arst_n),
        .set (evt_set[i]),
        .clr (status_clr[i]),
        .hold_zero (status_hold0[i]),
        .q (status_q[i])
      );
    end
    else
    begin : g_zero
      assign status_q[i] = 1'b0;
    end
  end

  // ****************************************************************
  // Uncorrectable error mask
  // ****************************************************************
  logic [aer_pkg::DATA_W-1:0] mask_q;
  logic [aer_pkg::DATA_W-1:0] mask_d;
  logic [aer_pkg::DATA_W-1:0] mask_we;
  logic mask_wr;

  // Only implemented positions store; 14, 15 and reserved read zero
  assign mask_wr = wr_mask;
  assign mask_we = mask_wr ? impl_only(wr_lanes, aer_pkg::MASK_IMPL) : '0;
  assign mask_d = (mask_q & ~mask_we) | (cfg_wdata & mask_we);

  // ****************************************************************
  // Mask storage
  // ****************************************************************

  // Sticky: kept through the hot reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_q <= aer_pkg::MASK_RST;
    else
      mask_q <= mask_d;
  end

  // ****************************************************************
  // Logging and reporting
  // ****************************************************************
  aer_err_if err_bus ();

  logic [aer_pkg::DATA_W-1:0] mask_eff;

  // The obsolete mask bit stores a value but gates nothing
  always_comb
  begin
    mask_eff = mask_q;
    mask_eff[aer_pkg::BIT_OBSOLETE] = 1'b0;
  end

  // Masked events still set status above; they only lose logging,
  // the first error pointer update and the report.
  assign err_bus.new_err = evt_set & ~mask_eff;
  assign err_bus.status = status_q;

  aer_err_report u_report (
    .core_clk (core_clk),
    .arst_n (arst_n),
    .err (err_bus.snk),
    .err_report (err_report),
    .first_error_pointer (first_error_pointer),
    .first_error_valid (first_error_valid)
  );

  // ****************************************************************
  // Read select
  // ****************************************************************
  logic [aer_pkg::DATA_W-1:0] status_word;
  logic [aer_pkg::DATA_W-1:0] mask_word;
  logic [aer_pkg::DATA_W-1:0] rd_word;
  logic [aer_pkg::DATA_W-1:0] rdata_d;

  // Positions are cut at the read side as well as at storage, so a
  // later change to either cannot let a reserved bit show through
  assign status_word = impl_only(status_q, aer_pkg::STATUS_IMPL);
  assign mask_word = impl_only(mask_q, aer_pkg::MASK_IMPL);

  // Unmapped words read zero and ignore writes
  assign rd_word = hit_cap ? cap_word
    : hit_status ? status_word
    : hit_mask ? mask_word
    : '0;

  // Read data is the value before any write in the same request;
  // a write returns zero data.
  assign rdata_d = rd_hit ? rd_word : '0;

  // ****************************************************************
  // Read response
  // ****************************************************************
  logic [aer_pkg::DATA_W-1:0] rdata_q;
  logic ack_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  // Every request is answered one edge later, mapped or not, so a
  // requester never has to time out on this bank
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_q <= 1'b0;
    else
      ack_q <= cfg_req;
  end

  assign cfg_ack = ack_q;
  assign cfg_rdata = rdata_q;

endmodule : aer_regs

`default_nettype wire

// file: core/aer_pkg.sv
/*
  Constants shared by the error reporting register bank: register offsets,
  field positions, reset values and the sets of implemented bits.
  Assumes configuration offsets are byte addresses of aligned 32-bit words.
*/
// Functional notes
// - Capability identifier reads fixed 0x1
// - Capability version reads fixed 0x1
// - Bit 0 obsolete, carries no error behaviour
// - Link protocol fault sets status bit 4
// - Link loss sets bit 5 if capable
// - Poisoned packet sets status bit 12
// - Credit protocol fault sets status bit 13
// - Completion timeout bit 14 held zero
// - Completer abort bit 15 held zero
// - Unexpected completion sets status bit 16
// - Receive overflow sets status bit 17
// - Malformed packet sets status bit 18
// - End-to-end CRC failure sets bit 19
// - Unsupported request sets status bit 20
// - Access control bit 21 hardwired zero
// - Enabled double-bit error sets bit 31
// - Bit 31 reads zero when disabled
// - Mask bit 4 suppresses logging, pointer, report
// - Masking never blocks setting status bits
// - Sticky mask bits 0,4,5,12,13,16-19; 14,15 zero
package aer_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int WORD_LSB = 2;
  localparam logic [ADDR_W-1:0] OFF_CAP_HEADER = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_UE_STATUS = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_UE_MASK = 12'h108;

  // ****************************************************************
  // Capability header fields
  // ****************************************************************
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_ID_W = 16;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_VER_W = 4;
  localparam int NXT_LINK_LSB = 20;
  localparam int NXT_LINK_W = 12;
  localparam logic [CAP_ID_W-1:0] CAP_ID_VAL = 16'h0001;
  localparam logic [CAP_VER_W-1:0] CAP_VER_VAL = 4'h1;
  localparam logic [NXT_LINK_W-1:0] NXT_LINK_RST = 12'h200;

  // ****************************************************************
  // Uncorrectable error bit positions
  // ****************************************************************
  localparam int BIT_OBSOLETE = 0;
  localparam int BIT_LINK_PROTO = 4;
  localparam int BIT_LINK_LOSS = 5;
  localparam int BIT_POISONED = 12;
  localparam int BIT_CREDIT = 13;
  localparam int BIT_CPL_TIMEOUT = 14;
  localparam int BIT_CPL_ABORT = 15;
  localparam int BIT_UNEXP_CPL = 16;
  localparam int BIT_RX_OVERFLOW = 17;
  localparam int BIT_MALFORMED = 18;
  localparam int BIT_ECRC = 19;
  localparam int BIT_UNSUPPORTED = 20;
  localparam int BIT_ACS_VIOL = 21;
  localparam int BIT_DOUBLE_BIT = 31;
  localparam int PTR_W = 5;

  // Status bits that can ever be set, and mask bits that store a value
  localparam logic [DATA_W-1:0] STATUS_IMPL = 32'h801F_3030;
  localparam logic [DATA_W-1:0] MASK_IMPL = 32'h000F_3031;
  localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RST = 32'h0000_0000;

endpackage : aer_pkg

// file: core/aer_err_if.sv
/*
  Carrier between the register bank and the error reporting logic.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

interface aer_err_if;
  // Unmasked error events of this cycle
  logic [aer_pkg::DATA_W-1:0] new_err;
  // Current status register contents
  logic [aer_pkg::DATA_W-1:0] status;

  modport src (output new_err, output status);
  modport snk (input new_err, input status);
endinterface : aer_err_if

`default_nettype wire

// file: core/aer_sticky_bit.sv
/*
  One sticky write-one-to-clear status flag.
  Assumes set and clear are same-clock single-cycle terms.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_sticky_bit
(
  // Clock and fundamental reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic set,
  input wire logic clr,
  input wire logic hold_zero,
  // State
  output logic q
);

  logic flag_q;
  logic flag_d;

  // A set in the same cycle as a clear wins, so no event is lost
  assign flag_d = hold_zero ? 1'b0 : (set | (flag_q & ~clr));

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  assign q = flag_q;

endmodule : aer_sticky_bit

`default_nettype wire

// file: core/aer_err_report.sv
/*
  Error reporting: first error pointer and report pulse toward the root.
  Assumes new_err already excludes masked events.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_err_report
(
  // Clock and fundamental reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Events and status from the register bank
  aer_err_if.snk err,
  // Reporting outputs
  output logic err_report,
  output logic [aer_pkg::PTR_W-1:0] first_error_pointer,
  output logic first_error_valid
);

  function automatic logic [aer_pkg::PTR_W-1:0] lowest_bit(
    input logic [aer_pkg::DATA_W-1:0] v);
    logic [aer_pkg::PTR_W-1:0] idx;
    idx = '0;
    for (int i = aer_pkg::DATA_W - 1; i >= 0; i--)
      if (v[i])
        idx = aer_pkg::PTR_W'(i);
    return idx;
  endfunction : lowest_bit

  logic report_q;
  logic [aer_pkg::PTR_W-1:0] ptr_q;
  logic valid_q;
  logic any_new;
  logic ptr_live;
  logic take_new;

  assign any_new = |err.new_err;
  // Pointer is kept while the error it names stays logged
  assign ptr_live = valid_q & err.status[ptr_q];
  assign take_new = any_new & ~ptr_live;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      report_q <= 1'b0;
      ptr_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      report_q <= any_new;
      valid_q <= ptr_live | any_new;
      if (take_new)
        ptr_q <= lowest_bit(err.new_err);
    end
  end

  assign err_report = report_q;
  assign first_error_pointer = ptr_q;
  assign first_error_valid = valid_q;

endmodule : aer_err_report

`default_nettype wire

// file: verif/aer_regs_asserts.sv
/*
  Port checker for the error reporting register bank.
  Assumes it is bound onto aer_regs and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_regs_asserts
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Configuration port
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [aer_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic cfg_ack,
  input wire logic [aer_pkg::DATA_W-1:0] cfg_rdata,
  // Events and enables
  input wire logic link_protocol_fault,
  input wire logic poisoned_packet,
  input wire logic unsupported_request,
  input wire logic double_bit_reporting_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  wire logic rd = cfg_req && !cfg_write;
  wire logic rd_hdr = rd && cfg_addr[11:2] == aer_pkg::OFF_CAP_HEADER[11:2];
  wire logic rd_st = rd && cfg_addr[11:2] == aer_pkg::OFF_UE_STATUS[11:2];
  wire logic rd_msk = rd && cfg_addr[11:2] == aer_pkg::OFF_UE_MASK[11:2];

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_evt_read(ev);
    ev ##1 rd_st;
  endsequence
  property p_ack;
    cfg_ack == $past(cfg_req);
  endproperty
  property p_hdr;
    rd_hdr |=> cfg_rdata[19:0] == 20'h1_0001;
  endproperty
  property p_st_rsvd;
    rd_st |=> (cfg_rdata & ~aer_pkg::STATUS_IMPL) == 32'h0;
  endproperty
  property p_msk_rsvd;
    rd_msk |=> (cfg_rdata & ~aer_pkg::MASK_IMPL) == 32'h0;
  endproperty
  property p_wr_zero;
    cfg_req && cfg_write |=> cfg_rdata == 32'h0;
  endproperty
  property p_link_fault;
    s_evt_read(link_protocol_fault) |=> cfg_rdata[4];
  endproperty
  property p_poison;
    s_evt_read(poisoned_packet) |=> cfg_rdata[12];
  endproperty
  property p_unsup;
    s_evt_read(unsupported_request) |=> cfg_rdata[20];
  endproperty
  property p_dbe_off;
    (!double_bit_reporting_enable)[*2] ##0 rd_st |=> !cfg_rdata[31];
  endproperty

  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_hdr: assert property (p_hdr) else $error("header id or version wrong");
  a_st_rsvd: assert property (p_st_rsvd) else $error("status unused bit set");
  a_msk_rsvd: assert property (p_msk_rsvd) else $error("mask unused bit set");
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  a_link_fault: assert property (p_link_fault) else $error("bit 4 not set");
  a_poison: assert property (p_poison) else $error("bit 12 not set");
  a_unsup: assert property (p_unsup) else $error("bit 20 not set");
  a_dbe_off: assert property (p_dbe_off) else $error("bit 31 set while off");
endmodule : aer_regs_asserts

bind aer_regs aer_regs_asserts aer_regs_asserts_inst
(
  .core_clk(core_clk),
  .arst_n(arst_n),
  .cfg_req(cfg_req),
  .cfg_write(cfg_write),
  .cfg_addr(cfg_addr),
  .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata),
  .link_protocol_fault(link_protocol_fault),
  .poisoned_packet(poisoned_packet),
  .unsupported_request(unsupported_request),
  .double_bit_reporting_enable(double_bit_reporting_enable)
);

`default_nettype wire

// file: verif/aer_root_model.sv
/*
  Root complex end of the error reports: counts report pulses.
  Assumes reports are single-cycle pulses on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_root_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Reports from the port
  input wire logic err_report,
  output int report_count
);
  // A held report counts once per cycle, as one message per event
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      report_count <= 0;
    else if (err_report)
      report_count <= report_count + 1;
  end
endmodule : aer_root_model

`default_nettype wire

// file: verif/aer_uncorrectable_error_regs_test.sv
/*
  Self-checking bench of the error reporting register bank.
  Assumes aer_regs with its bound checker and the root model.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_uncorrectable_error_regs_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hot_rst = 1'b0;
  logic cfg_req = 1'b0;
  logic cfg_write = 1'b0;
  logic [11:0] cfg_addr = 12'h0;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic cfg_wr_lock = 1'b1;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic [9:0] ev = 10'h0;
  logic llc = 1'b0;
  logic dbe_en = 1'b0;
  logic err_report;
  logic [4:0] fep;
  logic fev;
  int report_count;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int exp_rpts = 0;
  int idx_q[$] = '{4, 5, 12, 13, 16, 17, 18, 19, 20, 31};
  logic [31:0] sts = 32'h0;
  logic [31:0] msk = 32'h0;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] bm;
  logic [3:0] be_r;
  logic fev_m = 1'b0;
  logic [4:0] fep_m = 5'h0;

  always #4 core_clk = ~core_clk;

  aer_regs aer_regs_inst
  (
    .core_clk(core_clk), .arst_n(arst_n), .hot_rst(hot_rst),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_wr_lock(cfg_wr_lock),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .link_protocol_fault(ev[0]), .unexpected_link_loss(ev[1]),
    .poisoned_packet(ev[2]), .credit_protocol_fault(ev[3]),
    .unexpected_completion(ev[4]), .receiver_overflow(ev[5]),
    .malformed_packet(ev[6]), .ecrc_failure(ev[7]),
    .unsupported_request(ev[8]), .double_bit_memory_error(ev[9]),
    .link_loss_reporting_capable(llc), .double_bit_reporting_enable(dbe_en),
    .err_report(err_report), .first_error_pointer(fep), .first_error_valid(fev)
  );

  aer_root_model aer_root_model_inst
  (
    .core_clk(core_clk), .arst_n(arst_n),
    .err_report(err_report), .report_count(report_count)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  // Ends with an idle cycle so the strobe never toggles twice at once
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d);
    cfg_req = 1'b1;
    cfg_write = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    tick();
    check({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
    cfg_req = 1'b0;
    tick();
  endtask : cfg

  // Leaves no idle cycle, so a following read lands right after the event
  task automatic fire(input logic [9:0] v);
    logic [31:0] hit;
    logic live;
    hit = 32'h0;
    foreach (idx_q[i])
      if (v[i])
        hit[idx_q[i]] = 1'b1;
    hit[5] = hit[5] & llc;
    hit[31] = hit[31] & dbe_en;
    // Pointer is kept while its flag stays set, else takes lowest unmasked
    live = fev_m & sts[fep_m];
    if (|(hit & ~msk) && !live)
      for (int i = 9; i >= 0; i--)
        if (hit[idx_q[i]] && !msk[idx_q[i]])
          fep_m = 5'(idx_q[i]);
    fev_m = live | (|(hit & ~msk));
    ev = v;
    tick();
    ev = 10'h0;
    sts = sts | hit;
    exp_rpts += int'(|(hit & ~msk));
    check({31'h0, err_report}, {31'h0, |(hit & ~msk)});
    check({26'h0, fev, fep}, {26'h0, fev_m, fep_m});
  endtask : fire

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'hB9064CE1));
    repeat (20) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    cfg(1'b0, 12'h100, 4'hF, 32'h0);
    check(rd, 32'h2001_0001);
    cfg(1'b0, 12'h10C, 4'hF, 32'h0);
    check(rd, 32'h0);
    cfg(1'b0, 12'h108, 4'hF, 32'h0);
    check(rd, 32'h0);
    fire(10'h084);
    check({26'h0, fev, fep}, {26'h0, 1'b1, 5'd12});
    cfg(1'b0, 12'h104, 4'hF, 32'h0);
    check(rd, sts);
    fire(10'h002);
    cfg(1'b1, 12'h100, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 12'h100, 4'hF, 32'h0);
    check(rd, 32'h2001_0001);
    cfg_wr_lock = 1'b0;
    cfg(1'b1, 12'h100, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 12'h100, 4'hF, 32'h0);
    check(rd, 32'hFFF1_0001);
    hot_rst = 1'b1;
    tick();
    hot_rst = 1'b0;
    cfg(1'b0, 12'h100, 4'hF, 32'h0);
    check(rd, 32'h2001_0001);
    cfg(1'b0, 12'h104, 4'hF, 32'h0);
    check(rd, sts);
    repeat (80)
    begin
      llc = 1'($urandom);
      dbe_en = 1'($urandom);
      tick();
      if (!dbe_en)
        sts[31] = 1'b0;
      r = $urandom;
      be_r = 4'($urandom);
      bm = {{8{be_r[3]}}, {8{be_r[2]}}, {8{be_r[1]}}, {8{be_r[0]}}};
      cfg(1'b1, 12'h108, be_r, r);
      msk = (msk & ~bm) | (r & bm & aer_pkg::MASK_IMPL);
      cfg(1'b0, 12'h108, 4'hF, 32'h0);
      check(rd, msk);
      fire(10'($urandom) & 10'($urandom));
      cfg(1'b0, 12'h104, 4'hF, 32'h0);
      check(rd, sts);
      r = $urandom;
      cfg(1'b1, 12'h104, be_r, r);
      sts = sts & ~(r & bm);
      cfg(1'b0, 12'h104, 4'hF, 32'h0);
      check(rd, sts);
    end
    check(32'(report_count), 32'(exp_rpts));
    print_verdict();
  end
endmodule : aer_uncorrectable_error_regs_test

`default_nettype wire
